// ===== rtl/rsf_pkg.sv
/*
 reset source flag package: register address, bit positions, reset values, pin count.
 assumes a byte-wide read port with address and strobe, one 100 MHz clock.
*/
package rsf_pkg;
   localparam logic [31:0] RSF_CAUSE_ADDR = 32'h4002_0440;
   localparam int RSF_BIT_SYS = 7;
   localparam int RSF_BIT_WDT = 4;
   localparam int RSF_BIT_PAR = 2;
   localparam int RSF_BIT_ILL = 1;
   localparam int RSF_BIT_VDT = 0;
   localparam logic [7:0] RSF_FLAGS_RST = 8'h00;
   localparam logic [7:0] RSF_LIVE_MASK = 8'h97;
   localparam logic RSF_PARDIS_RST = 1'b0;
   localparam int RSF_PIN_NUM = 4;

   typedef struct packed {
      logic sys;
      logic wdt;
      logic par;
      logic ill;
      logic vdt;
   } rsf_req_t;

   typedef enum logic [1:0] {
      RSF_PWR_DOWN,
      RSF_PWR_UP
   } rsf_pwr_t;
endpackage

// ===== rtl/rsf_sync.sv
/*
 two flip-flop synchroniser for a bus of levels.
 assumes inputs come from pins or analog comparators, asynchronous to clk_in.
*/
`timescale 1ns/1ps
module rsf_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_r;

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         meta_r <= INIT;
         q_out <= INIT;
      end else begin
         meta_r <= d_in;
         q_out <= meta_r;
      end
   end
endmodule

// ===== rtl/rsf_top.sv
/*
 reset source flag register, power-on reset hold, parity-disable control and
 pin state during reset.
 assumes: rstn_in is the block's own async reset (always-on domain);
 the reset-source blocks raise one-cycle requests on clk_in; pins arrive raw.
*/
`timescale 1ns/1ps

// Operation
// R1: cause register readable by byte access
// R2: external, power-on reset or read clear flags
// R3: bit 7 set on software reset request
// R4: bit 4 set on watchdog reset
// R5: bit 2 set on ram parity reset
// R6: bit 1 set on illegal access reset
// R7: bit 0 set on voltage detect reset
// R8: internal reset sets own flag, keeps others
// R9: power-on reset forces register to zero
// R10: assert at power-up, release on supply rise
// R11: hold reset while supply below drop threshold
// R12: any reset clears parity reset disable
// R13: four pins float on ext/por, else pulled high
// R14: software reads once and keeps copy
// R15: bits 6, 5, 3 read zero, ignore writes
// R16: read returns old value then clears
module rsf_top import rsf_pkg::*; (
   input wire logic clk_in,
   input wire logic rstn_in,
   input wire logic external_reset_pin_n_in,
   input wire logic supply_rise_ok_in,
   input wire logic supply_drop_low_in,
   input wire rsf_req_t req_in,
   input wire logic [31:0] addr_in,
   input wire logic rd_in,
   input wire logic wr_in,
   input wire logic [7:0] wdata_in,
   input wire logic pardis_wr_in,
   input wire logic pardis_in,
   output logic [7:0] rdata_out,
   output logic rvalid_out,
   output logic internal_reset_out,
   output logic parity_reset_disable_out,
   output logic [RSF_PIN_NUM-1:0] pin_oe_out,
   output logic [RSF_PIN_NUM-1:0] pin_pullup_out
);
   logic ext_n_s;
   logic rise_s;
   logic drop_s;
   rsf_pwr_t pwr_r;
   logic por_active;
   logic ext_active;
   logic cold_reset;
   logic any_int_req;
   logic rd_hit;
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [7:0] set_vec;

   rsf_sync #(.W(3), .INIT(3'h1)) u_sync (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .d_in({external_reset_pin_n_in, supply_rise_ok_in, supply_drop_low_in}),
      .q_out({ext_n_s, rise_s, drop_s})
   );

   // R10: R11: power-on hold state
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pwr_r <= RSF_PWR_DOWN;
      end else begin
         case (pwr_r)
            RSF_PWR_DOWN: if (rise_s && !drop_s) pwr_r <= RSF_PWR_UP;
            RSF_PWR_UP: if (drop_s) pwr_r <= RSF_PWR_DOWN;
            default: pwr_r <= RSF_PWR_DOWN;
         endcase
      end
   end

   assign por_active = (pwr_r == RSF_PWR_DOWN);
   assign ext_active = !ext_n_s;
   assign cold_reset = por_active || ext_active;
   assign any_int_req = |req_in;
   // R1: byte read decode at the printed address
   assign rd_hit = rd_in && (addr_in == RSF_CAUSE_ADDR);

   // R3: R4: R5: R6: R7: per-source set bits
   assign set_vec = {req_in.sys, 2'b00, req_in.wdt, 1'b0, req_in.par, req_in.ill, req_in.vdt};
   // R8: R16: read clears, a same-cycle request still sets; R15: dead bits masked
   assign flags_nxt = ((rd_hit ? RSF_FLAGS_RST : flags_r) | set_vec) & RSF_LIVE_MASK;

   // R2: R9: cold resets zero the flags
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         flags_r <= RSF_FLAGS_RST;
      end else if (cold_reset) begin
         flags_r <= RSF_FLAGS_RST;
      end else begin
         flags_r <= flags_nxt;
      end
   end

   // R16: data captured from pre-clear value
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         rdata_out <= 8'h00;
         rvalid_out <= 1'b0;
      end else begin
         rvalid_out <= rd_hit;
         rdata_out <= rd_hit ? flags_r : 8'h00;
      end
   end

   // internal reset: cold reset level, or one cycle per request
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         internal_reset_out <= 1'b1;
      end else begin
         internal_reset_out <= cold_reset || any_int_req;
      end
   end

   // R12: any reset clears parity disable
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         parity_reset_disable_out <= RSF_PARDIS_RST;
      end else if (cold_reset || any_int_req) begin
         parity_reset_disable_out <= RSF_PARDIS_RST;
      end else if (pardis_wr_in) begin
         parity_reset_disable_out <= pardis_in;
      end
   end

   // R13: float on cold reset, pull-up otherwise
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         pin_oe_out <= '0;
         pin_pullup_out <= '0;
      end else begin
         pin_oe_out <= '0;
         pin_pullup_out <= {RSF_PIN_NUM{!cold_reset}};
      end
   end

   // R3: sw request sets
   sys_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
      req_in.sys && !cold_reset |=> flags_r[RSF_BIT_SYS]) else $error("sw flag not set");
   // R4: watchdog sets
   wdt_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
      req_in.wdt && !cold_reset |=> flags_r[RSF_BIT_WDT]) else $error("watchdog flag not set");
   // R5: parity error sets
   par_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R5
      req_in.par && !cold_reset |=> flags_r[RSF_BIT_PAR]) else $error("parity flag not set");
   // R6: illegal access sets
   ill_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
      req_in.ill && !cold_reset |=> flags_r[RSF_BIT_ILL]) else $error("illegal flag not set");
   // R7: voltage detect sets
   vdt_set_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R7
      req_in.vdt && !cold_reset |=> flags_r[RSF_BIT_VDT]) else $error("voltage flag not set");
   // R8: other flags kept
   keep_flags_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8
      !cold_reset && !rd_hit |=> (flags_r & $past(flags_r)) == $past(flags_r)) else $error("flag lost");
   // R8: set wins over clear
   sequence read_set_seq;
      rd_hit && !cold_reset && any_int_req;
   endsequence
   set_wins_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R8
      read_set_seq |=> rvalid_out && flags_r == ($past(set_vec) & RSF_LIVE_MASK)) else $error("set lost on read");
   // R15: writes leave flags
   write_ignore_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
      wr_in && wdata_in != flags_r && !rd_hit && !any_int_req && !cold_reset |=> flags_r == $past(flags_r))
      else $error("write changed flags");
   // R15: dead bits zero
   dead_bits_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
      (flags_r & ~RSF_LIVE_MASK) == 8'h00) else $error("reserved bit set");
   // R9: cold reset zeroes
   cold_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R9
      cold_reset |=> flags_r == 8'h00) else $error("cold reset left flags");
   // R2: pin reset zeroes
   ext_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R2
      ext_active |=> flags_r == RSF_FLAGS_RST) else $error("pin reset left flags");
   // R16: read old, then clear
   sequence read_seq;
      rd_hit && !cold_reset && !any_int_req;
   endsequence
   read_clear_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
      read_seq |=> rvalid_out && rdata_out == $past(flags_r) && flags_r == 8'h00) else $error("read clear bad");
   // R1: other addresses refused
   addr_miss_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
      rd_in && addr_in != RSF_CAUSE_ADDR |=> !rvalid_out) else $error("miss answered");
   // R1: data zero when idle
   rdata_idle_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
      !rvalid_out |-> rdata_out == 8'h00) else $error("stale read data");
   // R1: valid only after hit
   rvalid_src_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
      rvalid_out |-> $past(rd_hit)) else $error("valid without read");
   // R10: hold until supply good
   sequence supply_good_seq;
      por_active && rise_s && !drop_s;
   endsequence
   por_release_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R10
      supply_good_seq |=> !por_active) else $error("power-on hold not released");
   // R10: reset out while held
   por_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R10
      por_active |=> internal_reset_out) else $error("reset low during power-on hold");
   // R11: drop reasserts reset
   drop_hold_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
      drop_s |=> ##1 internal_reset_out) else $error("reset released on drop");
   // R12: request clears disable
   pardis_clr_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
      any_int_req |=> !parity_reset_disable_out) else $error("parity disable kept");
   // R12: cold reset clears disable
   cold_pardis_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
      cold_reset |=> !parity_reset_disable_out) else $error("parity disable kept on cold reset");
   // R12: write lands otherwise
   pardis_write_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
      pardis_wr_in && !cold_reset && !any_int_req |=> parity_reset_disable_out == $past(pardis_in))
      else $error("parity disable write lost");
   // R13: float on cold reset
   pin_float_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
      cold_reset |=> pin_pullup_out == '0 && pin_oe_out == '0) else $error("pins not floating");
   // R13: pull-up on other resets
   int_pullup_a: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
      any_int_req && !cold_reset |=> pin_pullup_out == {RSF_PIN_NUM{1'b1}}) else $error("pull-up off");
endmodule

// ===== tb/rsf_src_model.sv
/*
 reset-source model: turns a source index into a one-clock request pulse.
 assumes fire_in is held by the bench for exactly one clock.
*/
`timescale 1ns/1ps
module rsf_src_model import rsf_pkg::*; (
   input wire logic fire_in,
   input wire logic [2:0] sel_in,
   output rsf_req_t req_out
);
   // index 0..4 picks sys, wdt, par, ill, vdt
   assign req_out = fire_in ? rsf_req_t'(5'h10 >> sel_in) : '0;
endmodule

// ===== tb/test_rsf_top.sv
/*
 self-checking bench for rsf_top: source requests, byte reads, cold resets.
 assumes one mapped address and requests pulsed through rsf_src_model.
*/
`timescale 1ns/1ps
module test_rsf_top import rsf_pkg::*; ;
   logic clk_in = 0, rstn_in = 0, ext_n = 1, rise = 0, drop = 0, rd = 0, wr = 0, pw = 0, pv = 0, fire = 0;
   logic [31:0] addr = RSF_CAUSE_ADDR;
   logic [7:0] wd = 8'h00, rdata, expv = 8'h00, lfsr = 8'h33;
   logic [2:0] sel = 3'h0;
   logic rvalid, ires, pdis;
   logic [3:0] oe, pu;
   rsf_req_t req;
   int mismatches = 0, n_checks = 0, cyc = 0, i;
   rsf_src_model SRC (.fire_in(fire), .sel_in(sel), .req_out(req));
   rsf_top DUT (.clk_in(clk_in), .rstn_in(rstn_in), .external_reset_pin_n_in(ext_n),
      .supply_rise_ok_in(rise), .supply_drop_low_in(drop), .req_in(req), .addr_in(addr),
      .rd_in(rd), .wr_in(wr), .wdata_in(wd), .pardis_wr_in(pw), .pardis_in(pv), .rdata_out(rdata),
      .rvalid_out(rvalid), .internal_reset_out(ires), .parity_reset_disable_out(pdis),
      .pin_oe_out(oe), .pin_pullup_out(pu));
   function automatic logic [7:0] step(logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] bitof(logic [2:0] k);
      int p[5] = '{RSF_BIT_SYS, RSF_BIT_WDT, RSF_BIT_PAR, RSF_BIT_ILL, RSF_BIT_VDT};
      return 8'h01 << p[k];
   endfunction
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic check(logic [7:0] seen, logic [7:0] want);
      n_checks++;
      if (seen !== want) begin
         mismatches++;
         $display("CHECK FAILED t=%0t seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic cyc_n(int n);
      repeat (n) @(negedge clk_in);
   endtask
   // state word: pull-ups, reset out, parity disable; pins never driven
   task automatic state(logic [7:0] want);
      check({pdis, ires, 2'h0, pu}, want);
      check({4'h0, oe}, 8'h00);
   endtask
   task automatic rd_chk(logic [31:0] a);
      addr = a;
      rd = 1;
      cyc_n(1);
      rd = 0;
      check({7'h00, rvalid}, {7'h00, a == RSF_CAUSE_ADDR});
      check(rdata, (a == RSF_CAUSE_ADDR) ? expv : 8'h00);
      if (a == RSF_CAUSE_ADDR)
         expv = 8'h00;
      cyc_n(1);
   endtask
   task automatic pulse(logic [2:0] k);
      sel = k;
      fire = 1;
      cyc_n(1);
      fire = 0;
      state(8'h4f);
      expv = expv | bitof(k);
      cyc_n(4);
   endtask
   initial begin
      forever #5 clk_in = ~clk_in;
   end
   always @(posedge clk_in) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         close_out();
      end
   end
   initial begin
      cyc_n(8);
      rstn_in = 1;
      cyc_n(4);
      state(8'h40);
      rise = 1;
      cyc_n(6);
      state(8'h0f);
      for (i = 0; i < 5; i++) begin
         pulse(i[2:0]);
         rd_chk(RSF_CAUSE_ADDR);
      end
      for (i = 0; i < 12; i++) begin
         lfsr = step(lfsr);
         pv = 1;
         pw = 1;
         cyc_n(1);
         pw = 0;
         cyc_n(1);
         state(8'h8f);
         pulse(3'(lfsr % 5));
         pulse(3'((lfsr / 5) % 5));
         addr = RSF_CAUSE_ADDR;
         wd = lfsr;
         wr = 1;
         cyc_n(1);
         wr = 0;
         rd_chk(RSF_CAUSE_ADDR ^ 32'(lfsr));
         rd_chk(RSF_CAUSE_ADDR);
         rd_chk(RSF_CAUSE_ADDR);
      end
      pulse(3'h1);
      drop = 1;
      cyc_n(5);
      state(8'h40);
      drop = 0;
      cyc_n(6);
      expv = 8'h00;
      rd_chk(RSF_CAUSE_ADDR);
      pulse(3'h3);
      ext_n = 0;
      cyc_n(5);
      state(8'h40);
      ext_n = 1;
      cyc_n(6);
      expv = 8'h00;
      rd_chk(RSF_CAUSE_ADDR);
      // corner: a request lands in the cycle of the read
      pulse(3'h0);
      addr = RSF_CAUSE_ADDR;
      sel = 3'h2;
      fire = 1;
      rd = 1;
      cyc_n(1);
      fire = 0;
      rd = 0;
      check(rdata, expv);
      expv = bitof(3'h2);
      cyc_n(1);
      rd_chk(RSF_CAUSE_ADDR);
      close_out();
   end
endmodule
